// ### core/mrs_consts.svh
// Register indices, reset values and datapath constants for result scaling.
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH
// Register index; the byte address on the bus is four times the index.
`define MRS_IDX_SHIFT_A 8'h8e
`define MRS_IDX_SHIFT_B 8'h8f
`define MRS_IDX_GAIN 8'h92
`define MRS_IDX_OFFSET 8'ha2
`define MRS_IDX_READING 8'h64
// Address width on the bus and the bits that carry the index.
`define MRS_ADDR_W 12
`define MRS_IDX_LSB 2
// Reset values: unity gain, zero offset, no shift.
`define MRS_GAIN_RST 16'h8000
`define MRS_OFFSET_RST 16'h0000
`define MRS_SHIFT_RST 3'h0
// Gain is a fraction with this many bits below the point.
`define MRS_GAIN_FRAC 15
`define MRS_CLAMP 16'hfff8
`define MRS_SHIFT_MAX 3'h4
// Bus answers.
`define MRS_RESP_OKAY 2'h0
`define MRS_RESP_SLVERR 2'h2
`endif

// ### core/mrs_pkg.sv
// Types shared by the monitor result scaling block.
`include "mrs_consts.svh"
package mrs_pkg;
	typedef struct packed {
		logic awvalid;
		logic [`MRS_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`MRS_ADDR_W-1:0] araddr;
		logic rready;
	} mrs_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mrs_axi_rsp_s;

	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [11:0] raw;
	} mrs_conv_s;

	typedef struct packed {
		logic [3:0][15:0] gain;
		logic [3:0][15:0] offset;
		logic [3:0][2:0] shift;
		logic [3:0][15:0] reading;
		logic s1Valid;
		logic [1:0] s1Chan;
		logic [16:0] s1Scaled;
		logic awRdy;
		logic awHeld;
		logic awBad;
		logic [7:0] awIdx;
		logic wRdy;
		logic wHeld;
		logic wLane0;
		logic [7:0] wData;
		logic bValid;
		logic [1:0] bResp;
		logic arRdy;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} mrs_state_s;
endpackage : mrs_pkg

// ### core/mrs_scaling.sv
// Gain, offset, clamp and shift datapath with its AXI4-Lite register file.
`timescale 1ns/1ps
`include "mrs_consts.svh"
// How it works
// (R1) Each of the four channels is scaled with its own gain and offset.
// (R2) Readings are 16 bits: zero at calibrated null, FFF0h for a full-scale conversion at unity gain.
// (R3) Gain is 16 bits, every bit writable; a larger gain reads larger.
// (R4) Offset is added after gain, so a negated null reading reads zero.
// (R5) An overflow is held at FFF8h divided by two to the shift count.
// (R6) The 12-bit conversion sits left-justified in 16 bits, low nibble zero.
// (R7) Shift counts 0 to 4 are honoured, larger field values act as 4.
// (R8) Shift fields are 3 bits, reset 0: 8Eh bits 6:4 and 2:0, 8Fh bits 6:4.
// (R9) Gain pairs sit at 92h-99h, offset pairs at A2h-A9h, in channel order.
// (R10) Gain, offset, clamp, shift apply in order before the reading updates.
module mrs_scaling
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Converter front end, same clock domain.
	input wire mrs_pkg::mrs_conv_s conv,
	// Register bus.
	input wire mrs_pkg::mrs_axi_req_s axiReq,
	output mrs_pkg::mrs_axi_rsp_s axiRsp
);
	mrs_pkg::mrs_state_s st_r;
	mrs_pkg::mrs_state_s st_nxt;
	logic doWrite;

	// Effective shift; the supply channel has no shift field.
	function automatic logic [2:0] shiftOf(input mrs_pkg::mrs_state_s s,
		input logic [1:0] ch);
		logic [2:0] f;
		f = s.shift[ch];
		if (ch == 2'h0)
			f = 3'h0;
		else if (f > `MRS_SHIFT_MAX) // [R7]
			f = `MRS_SHIFT_MAX;
		return f;
	endfunction : shiftOf

	// Offset add, clamp and shift of one gain-scaled value.
	function automatic logic [15:0] finish(input logic [16:0] scaled,
		input logic [15:0] ofs, input logic [2:0] sh);
		logic signed [18:0] sum;
		logic [15:0] lim;
		logic [15:0] cl;
		sum = $signed({2'b00, scaled}) + $signed({{3{ofs[15]}}, ofs}); // [R4]
		lim = `MRS_CLAMP >> sh; // [R5]
		if (sum < 0)
			cl = 16'h0000;
		else if (sum > $signed({3'b000, lim}))
			cl = lim; // [R5]
		else
			cl = sum[15:0];
		return cl << sh; // [R10]
	endfunction : finish

	// Left-justify the conversion and multiply by the gain fraction.
	function automatic logic [16:0] scale(input logic [11:0] raw,
		input logic [15:0] g);
		logic [31:0] p;
		p = {raw, 4'h0} * g; // [R6] [R3]
		return p[`MRS_GAIN_FRAC +: 17];
	endfunction : scale

	// Register read decode: hit flag and byte of data.
	function automatic logic [8:0] regRead(input mrs_pkg::mrs_state_s s,
		input logic [7:0] idx);
		logic [7:0] rel;
		logic [8:0] r;
		r = 9'h000;
		if (idx == `MRS_IDX_SHIFT_A)
			r = {1'b1, 1'b0, s.shift[1], 1'b0, s.shift[2]}; // [R8]
		else if (idx == `MRS_IDX_SHIFT_B)
			r = {1'b1, 1'b0, s.shift[3], 4'h0};
		else if (idx >= `MRS_IDX_GAIN && idx < `MRS_IDX_GAIN + 8'h08)
		begin
			rel = idx - `MRS_IDX_GAIN;
			r = {1'b1, rel[0] ? s.gain[rel[2:1]][7:0]
				: s.gain[rel[2:1]][15:8]};
		end
		else if (idx >= `MRS_IDX_OFFSET && idx < `MRS_IDX_OFFSET + 8'h08)
		begin
			rel = idx - `MRS_IDX_OFFSET;
			r = {1'b1, rel[0] ? s.offset[rel[2:1]][7:0]
				: s.offset[rel[2:1]][15:8]};
		end
		else if (idx >= `MRS_IDX_READING && idx < `MRS_IDX_READING + 8'h08)
		begin
			rel = idx - `MRS_IDX_READING;
			r = {1'b1, rel[0] ? s.reading[rel[2:1]][7:0]
				: s.reading[rel[2:1]][15:8]};
		end
		return r;
	endfunction : regRead

	// Next state: bus channels, register writes and the two-stage datapath.
	always_comb
	begin
		logic [7:0] rel;
		logic [8:0] rd;
		logic ok;
		rel = 8'h00;
		rd = 9'h000;
		ok = 1'b0;
		st_nxt = st_r;
		doWrite = 1'b0;
		// Address and data are taken independently, in either order.
		if (st_r.awRdy && axiReq.awvalid)
		begin
			st_nxt.awHeld = 1'b1;
			st_nxt.awIdx = axiReq.awaddr[`MRS_IDX_LSB +: 8];
			st_nxt.awBad = |axiReq.awaddr[`MRS_ADDR_W-1:`MRS_IDX_LSB+8];
		end
		if (st_r.wRdy && axiReq.wvalid)
		begin
			st_nxt.wHeld = 1'b1;
			st_nxt.wData = axiReq.wdata[7:0];
			st_nxt.wLane0 = axiReq.wstrb[0];
		end
		if (st_r.awHeld && st_r.wHeld && !st_r.bValid)
		begin
			doWrite = 1'b1;
			st_nxt.awHeld = 1'b0;
			st_nxt.wHeld = 1'b0;
			st_nxt.bValid = 1'b1;
			ok = !st_r.awBad;
			rel = st_r.awIdx - `MRS_IDX_GAIN;
			if (st_r.awBad)
				ok = 1'b0;
			else if (st_r.awIdx == `MRS_IDX_SHIFT_A)
			begin
				if (st_r.wLane0)
				begin
					st_nxt.shift[1] = st_r.wData[6:4]; // [R8]
					st_nxt.shift[2] = st_r.wData[2:0]; // [R8]
				end
			end
			else if (st_r.awIdx == `MRS_IDX_SHIFT_B)
			begin
				if (st_r.wLane0)
					st_nxt.shift[3] = st_r.wData[6:4]; // [R8]
			end
			else if (rel < 8'h08)
			begin
				if (st_r.wLane0 && rel[0])
					st_nxt.gain[rel[2:1]][7:0] = st_r.wData; // [R9] [R3]
				else if (st_r.wLane0)
					st_nxt.gain[rel[2:1]][15:8] = st_r.wData; // [R9] [R3]
			end
			else if (st_r.awIdx >= `MRS_IDX_OFFSET
				&& st_r.awIdx < `MRS_IDX_OFFSET + 8'h08)
			begin
				rel = st_r.awIdx - `MRS_IDX_OFFSET;
				if (st_r.wLane0 && rel[0])
					st_nxt.offset[rel[2:1]][7:0] = st_r.wData; // [R9] [R1]
				else if (st_r.wLane0)
					st_nxt.offset[rel[2:1]][15:8] = st_r.wData; // [R9] [R1]
			end
			else
				ok = 1'b0; // Readings and holes are not writable.
			st_nxt.bResp = ok ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
		end
		if (st_r.bValid && axiReq.bready)
			st_nxt.bValid = 1'b0;
		// Read: one answer outstanding, data captured at the handshake.
		if (st_r.rValid && axiReq.rready)
			st_nxt.rValid = 1'b0;
		if (st_r.arRdy && axiReq.arvalid)
		begin
			rd = regRead(st_r, axiReq.araddr[`MRS_IDX_LSB +: 8]);
			if (|axiReq.araddr[`MRS_ADDR_W-1:`MRS_IDX_LSB+8])
				rd = 9'h000;
			st_nxt.rValid = 1'b1;
			st_nxt.rData = {24'h000000, rd[7:0]};
			st_nxt.rResp = rd[8] ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
		end
		st_nxt.awRdy = !st_nxt.awHeld && !st_nxt.bValid;
		st_nxt.wRdy = !st_nxt.wHeld && !st_nxt.bValid;
		st_nxt.arRdy = !st_nxt.rValid;
		// Stage one multiplies; stage two finishes and stores, so the
		// reading only ever changes to a fully processed value.
		st_nxt.s1Valid = conv.valid;
		st_nxt.s1Chan = conv.chan;
		st_nxt.s1Scaled = scale(conv.raw, st_r.gain[conv.chan]); // [R1]
		if (st_r.s1Valid)
			st_nxt.reading[st_r.s1Chan] = finish(st_r.s1Scaled,
				st_r.offset[st_r.s1Chan], shiftOf(st_r, st_r.s1Chan)); // [R10]
	end

	// State register.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
			st_r.gain <= {4{`MRS_GAIN_RST}};
			st_r.offset <= {4{`MRS_OFFSET_RST}};
			st_r.shift <= {4{`MRS_SHIFT_RST}}; // [R8]
		end
		else
			st_r <= st_nxt;
	end

	// Bus outputs come straight from state flops.
	assign axiRsp.awready = st_r.awRdy;
	assign axiRsp.wready = st_r.wRdy;
	assign axiRsp.bvalid = st_r.bValid;
	assign axiRsp.bresp = st_r.bResp;
	assign axiRsp.arready = st_r.arRdy;
	assign axiRsp.rvalid = st_r.rValid;
	assign axiRsp.rdata = st_r.rData;
	assign axiRsp.rresp = st_r.rResp;

	// Checks on the datapath and register file.
	sequence convIn;
		conv.valid;
	endsequence
	sequence stageOne;
		st_r.s1Valid;
	endsequence

	scale_uses_gain_a: assert property (@(posedge mclk) // [R3]
		disable iff (!reset_n)
		convIn |=> st_r.s1Scaled == scale($past(conv.raw),
			$past(st_r.gain[conv.chan])))
		else $error("Scaled value does not follow the gain.");
	order_of_steps_a: assert property (@(posedge mclk) // [R10]
		disable iff (!reset_n)
		convIn ##1 stageOne |=> st_r.reading[$past(st_r.s1Chan)]
			== finish($past(st_r.s1Scaled), $past(st_r.offset[st_r.s1Chan]),
				$past(shiftOf(st_r, st_r.s1Chan))))
		else $error("Reading not gain, offset, clamp then shift.");
	clamp_limit_a: assert property (@(posedge mclk) // [R5]
		disable iff (!reset_n)
		stageOne and (st_r.s1Chan == 2'h0 && st_r.offset[0] == 16'h0000
			&& st_r.s1Scaled > {1'b0, `MRS_CLAMP})
			|=> st_r.reading[0] == `MRS_CLAMP)
		else $error("Overflow not held at the clamp.");
	null_gives_zero_a: assert property (@(posedge mclk) // [R4]
		disable iff (!reset_n)
		stageOne and ($signed({2'b00, st_r.s1Scaled})
			+ $signed({{3{st_r.offset[st_r.s1Chan][15]}},
			st_r.offset[st_r.s1Chan]}) <= 0)
			|=> st_r.reading[$past(st_r.s1Chan)] == 16'h0000)
		else $error("Nulled input does not read zero.");
	zero_nibble_a: assert property (@(posedge mclk) // [R6]
		disable iff (!reset_n)
		convIn and (st_r.gain[conv.chan] == `MRS_GAIN_RST)
			|=> st_r.s1Scaled[3:0] == 4'h0)
		else $error("Unity gain left resolution in the low nibble.");
	shift_reset_a: assert property (@(posedge mclk) // [R8]
		$rose(reset_n) |-> st_r.shift == '0)
		else $error("Shift fields not zero after reset.");
	shift_limit_a: assert property (@(posedge mclk) // [R7]
		disable iff (!reset_n)
		stageOne and (shiftOf(st_r, st_r.s1Chan) == 3'h4)
			|=> st_r.reading[$past(st_r.s1Chan)][3:0] == 4'h0)
		else $error("Four-step shift left low bits set.");
	gain_write_a: assert property (@(posedge mclk) // [R9]
		disable iff (!reset_n)
		doWrite && st_r.wLane0 && !st_r.awBad && st_r.awIdx == `MRS_IDX_GAIN
			|=> st_r.gain[0][15:8] == $past(st_r.wData) && st_r.bValid)
		else $error("Supply gain byte not written.");
	offset_write_a: assert property (@(posedge mclk) // [R1]
		disable iff (!reset_n)
		doWrite && st_r.wLane0 && !st_r.awBad
			&& st_r.awIdx == `MRS_IDX_OFFSET + 8'h07
			|=> st_r.offset[3][7:0] == $past(st_r.wData))
		else $error("Third monitor offset byte not written.");
	read_holds_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st_r.rValid && !axiReq.rready |=> st_r.rValid && $stable(st_r.rData))
		else $error("Read answer dropped before it was taken.");
endmodule : mrs_scaling

// ### testbench/mrs_conv_model.sv
// Behavioural model of the converter front end that offers conversions.
`timescale 1ns/1ps
module mrs_conv_model
(
	// Clock.
	input wire logic mclk,
	// Conversion offer towards the block.
	output mrs_pkg::mrs_conv_s conv
);
	// Nothing is offered until the bench asks for a conversion.
	initial conv = '0;

	// One conversion for one cycle; afterwards the lines show the inverse
	// of the last value, so a block that samples them late sees garbage.
	task automatic send(input logic [1:0] ch, input logic [11:0] raw);
		begin
			@(posedge mclk);
			conv.valid <= 1'b1;
			conv.chan <= ch;
			conv.raw <= raw;
			@(posedge mclk);
			conv.valid <= 1'b0;
			conv.chan <= ~ch;
			conv.raw <= ~raw;
		end
	endtask : send
endmodule : mrs_conv_model

// ### testbench/tb_mrs_scaling.sv
// Self-checking testbench for the monitor result scaling block.
`timescale 1ns/1ps
`include "mrs_consts.svh"
module tb_mrs_scaling;
	typedef struct packed {
		logic [1:0] ch;
		logic [11:0] raw;
		logic [15:0] gain;
		logic [15:0] ofs;
		logic [7:0] shA;
		logic [7:0] shB;
		logic [15:0] expRd;
	} mrs_row_s;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	mrs_pkg::mrs_axi_req_s req = '0;
	mrs_pkg::mrs_axi_rsp_s rsp;
	mrs_pkg::mrs_conv_s conv;
	mrs_row_s rows [7];
	mrs_row_s r;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] gi, oi, ri, hi, lo;
	logic [1:0] rs;

	mrs_scaling u_dut (.mclk(mclk), .reset_n(reset_n), .conv(conv),
		.axiReq(req), .axiRsp(rsp));
	mrs_conv_model u_conv (.mclk(mclk), .conv(conv));

	// Clock at 200 MHz.
	always #2.5 mclk = ~mclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			cmp_count++;
			if (seen !== exp)
			begin
				err_total++;
				$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask : chk

	// Write one register byte; address and data are held until taken.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er);
		begin
			req.awaddr <= {2'b00, idx, 2'b00};
			req.wdata <= {24'h0, d};
			req.wstrb <= 4'hf;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
			do
			begin
				@(posedge mclk);
				if (rsp.awready === 1'b1)
					req.awvalid <= 1'b0;
				if (rsp.wready === 1'b1)
					req.wvalid <= 1'b0;
			end
			while (rsp.bvalid !== 1'b1);
			req.bready <= 1'b0;
			chk({30'h0, rsp.bresp}, {30'h0, er});
			// Let an edge pass so a following call never re-drives bready now.
			@(posedge mclk);
		end
	endtask : wr

	// Read one register byte and its response code.
	task automatic rd(input logic [7:0] idx, output logic [7:0] d,
		output logic [1:0] rr);
		begin
			req.araddr <= {2'b00, idx, 2'b00};
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
			do
			begin
				@(posedge mclk);
				if (rsp.arready === 1'b1)
					req.arvalid <= 1'b0;
			end
			while (rsp.rvalid !== 1'b1);
			d = rsp.rdata[7:0];
			rr = rsp.rresp;
			req.rready <= 1'b0;
			// Let an edge pass so a following call never re-drives rready now.
			@(posedge mclk);
		end
	endtask : rd

	task automatic close_out;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
			if (err_total == 0 && cmp_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask : close_out

	// A hang is cut short well beyond the expected run length.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	// Main sequence: table rows, then the awkward cases.
	initial
	begin
		rows[0] = '{2'h1, 12'h800, 16'h8000, 16'h0000, 8'h00, 8'h00, 16'h8000};
		rows[1] = '{2'h2, 12'h100, 16'hffff, 16'h0000, 8'h03, 8'h00, 16'hfff8};
		rows[2] = '{2'h0, 12'hfff, 16'hffff, 16'h0000, 8'h00, 8'h00, 16'hfff8};
		rows[3] = '{2'h3, 12'h100, 16'h8000, 16'hf000, 8'h00, 8'h00, 16'h0000};
		rows[4] = '{2'h1, 12'h200, 16'h8000, 16'h0010, 8'h10, 8'h00, 16'h4020};
		rows[5] = '{2'h3, 12'h100, 16'h8000, 16'h0000, 8'h00, 8'h40, 16'hfff0};
		// A shift field of 7 must act as a shift of four.
		rows[6] = '{2'h3, 12'h100, 16'h8000, 16'h0000, 8'h00, 8'h70, 16'hfff0};
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 7; i++)
		begin
			r = rows[i];
			gi = `MRS_IDX_GAIN + {5'h0, r.ch, 1'b0};
			oi = `MRS_IDX_OFFSET + {5'h0, r.ch, 1'b0};
			ri = `MRS_IDX_READING + {5'h0, r.ch, 1'b0};
			wr(`MRS_IDX_SHIFT_A, r.shA, `MRS_RESP_OKAY);
			wr(`MRS_IDX_SHIFT_B, r.shB, `MRS_RESP_OKAY);
			wr(gi, r.gain[15:8], `MRS_RESP_OKAY);
			wr(gi + 8'h01, r.gain[7:0], `MRS_RESP_OKAY);
			wr(oi, r.ofs[15:8], `MRS_RESP_OKAY);
			wr(oi + 8'h01, r.ofs[7:0], `MRS_RESP_OKAY);
			u_conv.send(r.ch, r.raw);
			repeat (2) @(posedge mclk);
			rd(ri, hi, rs);
			rd(ri + 8'h01, lo, rs);
			chk({16'h0, hi, lo}, {16'h0, r.expRd});
			rd(gi + 8'h01, lo, rs);
			chk({24'h0, lo}, {24'h0, r.gain[7:0]});
			$display("Row %0d done", i);
		end
		// Read-only reading and unmapped places are refused.
		wr(`MRS_IDX_READING, 8'h12, `MRS_RESP_SLVERR);
		rd(`MRS_IDX_READING, hi, rs);
		chk({24'h0, hi}, 32'h0000_00ff);
		wr(8'h90, 8'h55, `MRS_RESP_SLVERR);
		rd(8'h10, hi, rs);
		chk({22'h0, rs, hi}, {22'h0, `MRS_RESP_SLVERR, 8'h00});
		$display("Refusal test done");
		// A second reset restores the register defaults.
		reset_n <= 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(`MRS_IDX_GAIN, hi, rs);
		chk({24'h0, hi}, 32'h0000_0080);
		rd(`MRS_IDX_SHIFT_A, hi, rs);
		chk({24'h0, hi}, 32'h0000_0000);
		rd(`MRS_IDX_READING, hi, rs);
		chk({24'h0, hi}, 32'h0000_0000);
		$display("Reset test done");
		close_out();
	end
endmodule : tb_mrs_scaling
